/* tla_defines.vh */
// Purpose: Shared constants of the trilinear line alignment block
// Assumes: Register port with byte addresses, 32-bit words
// Notes:   Offsets are in hundredths of a line or pixel
`ifndef TLA_DEFINES_VH
`define TLA_DEFINES_VH

// Register byte addresses
`define TLA_A_CTRL     8'h00
`define TLA_A_MOVE     8'h04
`define TLA_A_OFFSET   8'h08
`define TLA_A_STATUS   8'h0C
`define TLA_A_RED      8'h10
`define TLA_A_BLUE     8'h14
`define TLA_A_TRIG     8'h18
`define TLA_A_LINE     8'h1C
`define TLA_A_AUTO     8'h20

// Control register fields
`define TLA_B_MODE     0
`define TLA_B_DIR      1
`define TLA_B_SRC_LO   2
`define TLA_B_SRC_HI   3
`define TLA_B_CHSEL    4
`define TLA_B_SWLVL    5

// Status register fields
`define TLA_S_MODE     0
`define TLA_S_DIR      1
`define TLA_S_PAUSED   2
`define TLA_S_BUSY     3

// Direction sources
`define TLA_SRC_SHAFT  2'h0
`define TLA_SRC_LINE   2'h1
`define TLA_SRC_SW     2'h2

// Reset values and arithmetic constants
`define TLA_MOVE_RST   16'h0064
`define TLA_OFF_RST    16'h0000
`define TLA_HUN        16'h0064
`define TLA_OFF_LIM    16'h012C
`define TLA_CENTER     16'h012C
`define TLA_CNT_MAX    16'hFFFF
`define TLA_DIV_STEPS  6'h28

`endif

/* tla_div.v */
// Purpose: Serial restoring divider for the automatic line offset
// Assumes: Operands stay stable only at the start pulse
// Notes:   One quotient bit per clock, result after 40 clocks
`timescale 1ns/1ps
`include "tla_defines.vh"

module tla_div (
    // Clock and reset
    input  wire        clk_in,
    input  wire        rst_in,
    // Request
    input  wire        start_in,
    input  wire [39:0] num_in,
    input  wire [31:0] den_in,
    // Answer
    output reg         busy_out,
    output reg         done_out,
    output reg  [39:0] quo_out
);
    reg  [31:0] rem_q;
    reg  [31:0] den_q;
    reg  [5:0]  cnt_q;
    wire [32:0] trial = {rem_q, quo_out[39]};
    wire        fits  = trial >= {1'b0, den_q};

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rem_q    <= 32'h0000_0000;
            den_q    <= 32'h0000_0000;
            cnt_q    <= 6'h00;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            quo_out  <= 40'h00_0000_0000;
        end else begin
            done_out <= 1'b0;
            if (start_in && !busy_out) begin
                rem_q    <= 32'h0000_0000;
                den_q    <= den_in;
                quo_out  <= num_in;
                cnt_q    <= `TLA_DIV_STEPS;
                busy_out <= 1'b1;
            end else if (busy_out) begin
                if (fits) begin
                    rem_q <= trial[31:0] - den_q;
                end else begin
                    rem_q <= trial[31:0];
                end
                quo_out <= {quo_out[38:0], fits};
                cnt_q   <= cnt_q - 6'h01;
                if (cnt_q == 6'h01) begin
                    busy_out <= 1'b0;
                    done_out <= 1'b1;
                end
            end
        end
    end
endmodule

/* tla_chan.v */
// Purpose: One color channel: line ring buffer with fractional delay
// Assumes: Delay never exceeds the ring depth minus two lines
// Notes:   Output lags the input pixel by one clock
`timescale 1ns/1ps
`include "tla_defines.vh"

module tla_chan #(
    parameter PIX_W  = 8,
    parameter PIX_AW = 12,
    parameter SLOT_W = 3
) (
    // Clock and reset
    input  wire             clk_in,
    input  wire             rst_in,
    // Incoming stream
    input  wire             valid_in,
    input  wire             lstart_in,
    input  wire [PIX_W-1:0] pix_in,
    // Delay in hundredths of a line
    input  wire [15:0]      delay_in,
    // Aligned pixel
    output reg  [PIX_W-1:0] pix_out
);
    reg  [PIX_W-1:0]  mem [0:(1<<(SLOT_W+PIX_AW))-1];
    reg  [SLOT_W-1:0] wslot_q;
    reg  [PIX_AW-1:0] wpix_q;
    wire [SLOT_W-1:0] cur_slot = lstart_in ? wslot_q + 1'b1 : wslot_q;
    wire [PIX_AW-1:0] cur_pix  = lstart_in ? {PIX_AW{1'b0}} : wpix_q + 1'b1;
    wire [15:0]       whole    = delay_in / `TLA_HUN;
    wire [15:0]       frac     = delay_in % `TLA_HUN;
    wire [SLOT_W-1:0] k        = whole[SLOT_W-1:0];
    wire [SLOT_W-1:0] slot_a   = cur_slot - k;
    wire [SLOT_W-1:0] slot_b   = cur_slot - k - 1'b1;
    // The line being written has no stored copy yet, so take the input
    wire [PIX_W-1:0]  near_pix = (k == {SLOT_W{1'b0}}) ? pix_in : mem[{slot_a, cur_pix}];
    wire [PIX_W-1:0]  far_pix  = mem[{slot_b, cur_pix}];
    wire [PIX_W+7:0]  mix      = near_pix * (`TLA_HUN - frac) + far_pix * frac;
    wire [PIX_W+7:0]  mixq     = mix / `TLA_HUN;

    always @(posedge clk_in) begin
        if (valid_in) begin
            mem[{cur_slot, cur_pix}] <= pix_in;
        end
    end

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wslot_q <= {SLOT_W{1'b0}};
            wpix_q  <= {PIX_AW{1'b1}};
            pix_out <= {PIX_W{1'b0}};
        end else if (valid_in) begin
            wslot_q <= cur_slot;
            wpix_q  <= cur_pix;
            pix_out <= mixq[PIX_W-1:0];
        end
    end
endmodule

/* tla_align.v */
// Purpose: Trilinear line alignment: red and blue shifted onto green
// Assumes: Stream is on SYS_CLK_IN; trigger and direction pins are not
// Notes:   Green is delayed by a fixed center so red/blue move both ways
// Contract
// - Shift red and blue to match green
// - Two modes: automatic and manual
// - Auto uses trigger interval, movement, direction
// - Manual applies separate red and blue offsets
// - Direction from shaft, input line, software level
// - Direction setting reverses alignment direction
// - Inverting source level reverses direction too
// - Movement per trigger in 0.01 pixel steps
// - Selector routes offset writes; 0.01 steps
// - Direction also exported for other functions
// - Reversing direction resumes paused output; code resumes only when a CTRL write flips the direction setting bit
`timescale 1ns/1ps
`include "tla_defines.vh"

module tla_align #(
    parameter PIX_W        = 8,
    parameter PIX_AW       = 12,
    parameter SLOT_W       = 3,
    parameter LINE_GAP_HUN = 16'h00C8
) (
    // Clock and reset
    input  wire             SYS_CLK_IN,
    input  wire             RST_IN,
    // Register port
    input  wire [7:0]       REG_ADDR_IN,
    input  wire [31:0]      REG_WDATA_IN,
    input  wire             REG_WR_IN,
    input  wire             REG_RD_IN,
    output reg  [31:0]      REG_RDATA_OUT,
    // Sensor stream
    input  wire             PIX_VALID_IN,
    input  wire             LINE_START_IN,
    input  wire [PIX_W-1:0] PIX_R_IN,
    input  wire [PIX_W-1:0] PIX_G_IN,
    input  wire [PIX_W-1:0] PIX_B_IN,
    // Motion pins and pause request
    input  wire             TRIG_IN,
    input  wire             SHAFT_DIR_IN,
    input  wire             LINE_DIR_IN,
    input  wire             BWD_PAUSE_IN,
    // Aligned stream
    output reg              PIX_VALID_OUT,
    output reg              LINE_START_OUT,
    output wire [PIX_W-1:0] PIX_R_OUT,
    output wire [PIX_W-1:0] PIX_G_OUT,
    output wire [PIX_W-1:0] PIX_B_OUT,
    // Status pins
    output reg              MOTION_DIR_OUT,
    output reg              SW_LEVEL_OUT,
    output reg              PAUSED_OUT
);
    // Software settings
    reg         align_mode_select_q;
    reg         motion_dir_setting_q;
    reg  [1:0]  motion_dir_source_select_q;
    reg         align_channel_select_q;
    reg         sw_level_out_bit0_q;
    reg  [15:0] movement_per_trigger_q;
    reg  [15:0] man_red_q;
    reg  [15:0] man_blue_q;

    // Synchronisers
    reg         trig_s1_q, trig_s2_q, trig_s3_q;
    reg         shaft_s1_q, shaft_s2_q;
    reg         ldir_s1_q, ldir_s2_q;

    // Measurements and results
    reg  [15:0] trig_cnt_q, trig_int_q;
    reg  [15:0] line_cnt_q, line_per_q;
    reg  [15:0] auto_off_q;
    reg  [15:0] red_del_q, blue_del_q;
    reg  [15:0] red_off_q, blue_off_q;
    reg         bwd_d_q;

    wire        wr_ctrl = REG_WR_IN && (REG_ADDR_IN == `TLA_A_CTRL);
    wire        trig_rise = trig_s2_q && !trig_s3_q;
    wire        div_busy;
    wire        div_done;
    wire [39:0] div_quo;

    function [15:0] clamp_off;
        input [15:0] v;
        begin
            if (!v[15] && (v > `TLA_OFF_LIM)) begin
                clamp_off = `TLA_OFF_LIM;
            end else if (v[15] && ((16'h0000 - v) > `TLA_OFF_LIM)) begin
                clamp_off = 16'h0000 - `TLA_OFF_LIM;
            end else begin
                clamp_off = v;
            end
        end
    endfunction

    function [15:0] flip;
        input [15:0] v;
        input        rev;
        begin
            flip = rev ? (16'h0000 - v) : v;
        end
    endfunction

    function [15:0] sat_inc;
        input [15:0] v;
        begin
            sat_inc = (v == `TLA_CNT_MAX) ? v : v + 16'h0001;
        end
    endfunction

    // Direction source select and level inversion
    reg src_level;
    always @* begin
        case (motion_dir_source_select_q)
            `TLA_SRC_SHAFT: src_level = shaft_s2_q;
            `TLA_SRC_LINE:  src_level = ldir_s2_q;
            `TLA_SRC_SW:    src_level = sw_level_out_bit0_q;
            default:        src_level = 1'b0;
        endcase
    end
    wire eff_dir = src_level ^ motion_dir_setting_q;

    // Pending offsets; in auto mode red and blue sit on opposite sides of green
    wire [15:0] auto_red  = flip(auto_off_q, eff_dir);
    wire [15:0] auto_blue = flip(auto_off_q, !eff_dir);
    wire [15:0] pend_red  = align_mode_select_q ? man_red_q : auto_red;
    wire [15:0] pend_blue = align_mode_select_q ? man_blue_q : auto_blue;
    wire [15:0] new_red   = `TLA_CENTER + clamp_off(pend_red);
    wire [15:0] new_blue  = `TLA_CENTER + clamp_off(pend_blue);
    // Whole line sees the new delay from its first pixel onward
    wire [15:0] red_now   = LINE_START_IN ? new_red : red_del_q;
    wire [15:0] blue_now  = LINE_START_IN ? new_blue : blue_del_q;

    // Automatic offset: 100 * gap * trigger interval / (movement * line period)
    wire [39:0] div_num = LINE_GAP_HUN * `TLA_HUN * trig_int_q;
    wire [31:0] div_den = movement_per_trigger_q * line_per_q;
    wire        div_go  = LINE_START_IN && !align_mode_select_q && !div_busy
                          && (div_den != 32'h0000_0000);

    tla_div u_div (
        .clk_in   (SYS_CLK_IN),
        .rst_in   (RST_IN),
        .start_in (div_go),
        .num_in   (div_num),
        .den_in   (div_den),
        .busy_out (div_busy),
        .done_out (div_done),
        .quo_out  (div_quo)
    );

    tla_chan #(.PIX_W(PIX_W), .PIX_AW(PIX_AW), .SLOT_W(SLOT_W)) u_red (
        .clk_in    (SYS_CLK_IN),
        .rst_in    (RST_IN),
        .valid_in  (PIX_VALID_IN),
        .lstart_in (LINE_START_IN),
        .pix_in    (PIX_R_IN),
        .delay_in  (red_now),
        .pix_out   (PIX_R_OUT)
    );

    tla_chan #(.PIX_W(PIX_W), .PIX_AW(PIX_AW), .SLOT_W(SLOT_W)) u_green (
        .clk_in    (SYS_CLK_IN),
        .rst_in    (RST_IN),
        .valid_in  (PIX_VALID_IN),
        .lstart_in (LINE_START_IN),
        .pix_in    (PIX_G_IN),
        .delay_in  (`TLA_CENTER),
        .pix_out   (PIX_G_OUT)
    );

    tla_chan #(.PIX_W(PIX_W), .PIX_AW(PIX_AW), .SLOT_W(SLOT_W)) u_blue (
        .clk_in    (SYS_CLK_IN),
        .rst_in    (RST_IN),
        .valid_in  (PIX_VALID_IN),
        .lstart_in (LINE_START_IN),
        .pix_in    (PIX_B_IN),
        .delay_in  (blue_now),
        .pix_out   (PIX_B_OUT)
    );

    // Pin synchronisers
    always @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            trig_s1_q  <= 1'b0;
            trig_s2_q  <= 1'b0;
            trig_s3_q  <= 1'b0;
            shaft_s1_q <= 1'b0;
            shaft_s2_q <= 1'b0;
            ldir_s1_q  <= 1'b0;
            ldir_s2_q  <= 1'b0;
        end else begin
            trig_s1_q  <= TRIG_IN;
            trig_s2_q  <= trig_s1_q;
            trig_s3_q  <= trig_s2_q;
            shaft_s1_q <= SHAFT_DIR_IN;
            shaft_s2_q <= shaft_s1_q;
            ldir_s1_q  <= LINE_DIR_IN;
            ldir_s2_q  <= ldir_s1_q;
        end
    end

    // Register writes
    always @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            align_mode_select_q        <= 1'b0;
            motion_dir_setting_q       <= 1'b0;
            motion_dir_source_select_q <= `TLA_SRC_SHAFT;
            align_channel_select_q     <= 1'b0;
            sw_level_out_bit0_q        <= 1'b0;
            movement_per_trigger_q     <= `TLA_MOVE_RST;
            man_red_q                  <= `TLA_OFF_RST;
            man_blue_q                 <= `TLA_OFF_RST;
        end else if (REG_WR_IN) begin
            case (REG_ADDR_IN)
                `TLA_A_CTRL: begin
                    align_mode_select_q        <= REG_WDATA_IN[`TLA_B_MODE];
                    motion_dir_setting_q       <= REG_WDATA_IN[`TLA_B_DIR];
                    motion_dir_source_select_q <= REG_WDATA_IN[`TLA_B_SRC_HI:`TLA_B_SRC_LO];
                    align_channel_select_q     <= REG_WDATA_IN[`TLA_B_CHSEL];
                    sw_level_out_bit0_q        <= REG_WDATA_IN[`TLA_B_SWLVL];
                end
                `TLA_A_MOVE: begin
                    movement_per_trigger_q <= REG_WDATA_IN[15:0];
                end
                `TLA_A_OFFSET: begin
                    if (align_channel_select_q) begin
                        man_blue_q <= REG_WDATA_IN[15:0];
                    end else begin
                        man_red_q <= REG_WDATA_IN[15:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Interval measurement, auto result, line boundary latching
    always @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            trig_cnt_q <= 16'h0000;
            trig_int_q <= 16'h0000;
            line_cnt_q <= 16'h0000;
            line_per_q <= 16'h0000;
            auto_off_q <= `TLA_OFF_RST;
            red_del_q  <= `TLA_CENTER;
            blue_del_q <= `TLA_CENTER;
            red_off_q  <= `TLA_OFF_RST;
            blue_off_q <= `TLA_OFF_RST;
        end else begin
            if (trig_rise) begin
                trig_int_q <= trig_cnt_q;
                trig_cnt_q <= 16'h0001;
            end else begin
                trig_cnt_q <= sat_inc(trig_cnt_q);
            end
            if (PIX_VALID_IN && LINE_START_IN) begin
                line_per_q <= line_cnt_q;
                line_cnt_q <= 16'h0001;
            end else begin
                line_cnt_q <= sat_inc(line_cnt_q);
            end
            if (div_done) begin
                // Saturate so a slow belt cannot wrap the offset
                auto_off_q <= (div_quo > {24'h00_0000, `TLA_OFF_LIM}) ?
                              `TLA_OFF_LIM : div_quo[15:0];
            end
            if (LINE_START_IN) begin
                red_del_q  <= new_red;
                blue_del_q <= new_blue;
                red_off_q  <= clamp_off(pend_red);
                blue_off_q <= clamp_off(pend_blue);
            end
        end
    end

    // Pause tracking and output stream
    always @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            bwd_d_q        <= 1'b0;
            PAUSED_OUT     <= 1'b0;
            PIX_VALID_OUT  <= 1'b0;
            LINE_START_OUT <= 1'b0;
            MOTION_DIR_OUT <= 1'b0;
            SW_LEVEL_OUT   <= 1'b0;
        end else begin
            bwd_d_q <= BWD_PAUSE_IN;
            // A new pause request wins over a simultaneous resume
            if (BWD_PAUSE_IN && !bwd_d_q) begin
                PAUSED_OUT <= 1'b1;
            end else if (wr_ctrl &&
                         (REG_WDATA_IN[`TLA_B_DIR] != motion_dir_setting_q)) begin
                PAUSED_OUT <= 1'b0;
            end
            PIX_VALID_OUT  <= PIX_VALID_IN && !PAUSED_OUT;
            LINE_START_OUT <= PIX_VALID_IN && LINE_START_IN && !PAUSED_OUT;
            MOTION_DIR_OUT <= eff_dir;
            SW_LEVEL_OUT   <= sw_level_out_bit0_q;
        end
    end

    // Register reads, data valid in the following cycle
    always @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            REG_RDATA_OUT <= 32'h0000_0000;
        end else if (REG_RD_IN) begin
            case (REG_ADDR_IN)
                `TLA_A_CTRL:   REG_RDATA_OUT <= {26'h000_0000, sw_level_out_bit0_q,
                                                 align_channel_select_q,
                                                 motion_dir_source_select_q,
                                                 motion_dir_setting_q,
                                                 align_mode_select_q};
                `TLA_A_MOVE:   REG_RDATA_OUT <= {16'h0000, movement_per_trigger_q};
                `TLA_A_OFFSET: REG_RDATA_OUT <= {16'h0000, align_channel_select_q ?
                                                 man_blue_q : man_red_q};
                `TLA_A_STATUS: REG_RDATA_OUT <= {28'h000_0000, div_busy, PAUSED_OUT,
                                                 eff_dir, align_mode_select_q};
                `TLA_A_RED:    REG_RDATA_OUT <= {16'h0000, red_off_q};
                `TLA_A_BLUE:   REG_RDATA_OUT <= {16'h0000, blue_off_q};
                `TLA_A_TRIG:   REG_RDATA_OUT <= {16'h0000, trig_int_q};
                `TLA_A_LINE:   REG_RDATA_OUT <= {16'h0000, line_per_q};
                `TLA_A_AUTO:   REG_RDATA_OUT <= {16'h0000, auto_off_q};
                default:       REG_RDATA_OUT <= 32'h0000_0000;
            endcase
        end else begin
            REG_RDATA_OUT <= 32'h0000_0000;
        end
    end
endmodule

/* tla_align_chk.sv */
// Purpose: Port-level checks of the line alignment block
// Assumes: Single clock domain, reset high
// Notes:   Watches top-level ports only
`timescale 1ns/1ps
module tla_align_chk #(
    parameter PIX_W = 8
) (
    // Clock and reset
    input wire             SYS_CLK_IN,
    input wire             RST_IN,
    // Register port
    input wire [7:0]       REG_ADDR_IN,
    input wire [31:0]      REG_WDATA_IN,
    input wire             REG_WR_IN,
    input wire             REG_RD_IN,
    input wire [31:0]      REG_RDATA_OUT,
    // Stream
    input wire             PIX_VALID_IN,
    input wire             LINE_START_IN,
    input wire             BWD_PAUSE_IN,
    input wire             PIX_VALID_OUT,
    input wire             LINE_START_OUT,
    input wire [PIX_W-1:0] PIX_G_OUT,
    input wire             SW_LEVEL_OUT,
    input wire             PAUSED_OUT
);
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (RST_IN);
    rd_idle_a: assert property (!$past(REG_RD_IN) |-> REG_RDATA_OUT == 32'h0000_0000)
        else $error("read data not idle");
    rd_unmap_a: assert property ($past(REG_RD_IN) && $past(REG_ADDR_IN) > 8'h20
        |-> REG_RDATA_OUT == 32'h0000_0000) else $error("unmapped read not zero");
    move_width_a: assert property ($past(REG_RD_IN) && $past(REG_ADDR_IN) == 8'h04
        |-> REG_RDATA_OUT[31:16] == 16'h0000) else $error("movement upper bits set");
    vout_cause_a: assert property (PIX_VALID_OUT |-> $past(PIX_VALID_IN))
        else $error("valid out without input");
    vout_pass_a: assert property ($past(PIX_VALID_IN) && !PAUSED_OUT && !$past(PAUSED_OUT)
        |-> PIX_VALID_OUT) else $error("valid pixel dropped");
    pause_gate_a: assert property (PAUSED_OUT && $past(PAUSED_OUT)
        |-> !PIX_VALID_OUT && !LINE_START_OUT) else $error("output while paused");
    lstart_out_a: assert property (LINE_START_OUT |-> PIX_VALID_OUT && $past(LINE_START_IN))
        else $error("line start out of place");
    pause_set_a: assert property ($rose(BWD_PAUSE_IN) |=> PAUSED_OUT)
        else $error("pause not taken");
    resume_cause_a: assert property ($fell(PAUSED_OUT)
        |-> $past(REG_WR_IN) && $past(REG_ADDR_IN) == 8'h00) else $error("resume without write");
    sw_level_a: assert property (REG_WR_IN && REG_ADDR_IN == 8'h00
        |=> ##1 SW_LEVEL_OUT == $past(REG_WDATA_IN[5], 2)) else $error("level not copied");
    sw_hold_a: assert property (!(REG_WR_IN && REG_ADDR_IN == 8'h00) |=> ##1 $stable(SW_LEVEL_OUT))
        else $error("level moved alone");
    pix_hold_a: assert property (!PIX_VALID_IN |=> $stable(PIX_G_OUT))
        else $error("pixel moved without valid");
endmodule

bind tla_align tla_align_chk #(.PIX_W(PIX_W)) chk (
    .SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN), .REG_ADDR_IN(REG_ADDR_IN),
    .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
    .REG_RDATA_OUT(REG_RDATA_OUT), .PIX_VALID_IN(PIX_VALID_IN),
    .LINE_START_IN(LINE_START_IN), .BWD_PAUSE_IN(BWD_PAUSE_IN),
    .PIX_VALID_OUT(PIX_VALID_OUT), .LINE_START_OUT(LINE_START_OUT),
    .PIX_G_OUT(PIX_G_OUT), .SW_LEVEL_OUT(SW_LEVEL_OUT), .PAUSED_OUT(PAUSED_OUT));

/* tla_sensor.sv */
// Purpose: Three-line sensor model with a trigger at each line
// Assumes: All channels carry the same value, twice the line number
// Notes:   Data lines show the inverse value between lines
`timescale 1ns/1ps
module tla_sensor #(
    parameter LEN = 16,
    parameter GAP = 4
) (
    // Clock and reset
    input  wire       clk_in,
    input  wire       rst_in,
    input  wire       en_in,
    // Stream and trigger
    output reg        valid_out,
    output reg        lstart_out,
    output reg  [7:0] pix_out,
    output reg        trig_out,
    output reg  [7:0] idx_out
);
    reg [7:0] pos_q;
    reg [7:0] idx_q;
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pos_q <= 8'h00;
            idx_q <= 8'h00;
        end else if (en_in) begin
            pos_q <= (pos_q == LEN + GAP - 1) ? 8'h00 : pos_q + 8'h01;
            if (pos_q == LEN + GAP - 1) begin
                idx_q <= idx_q + 8'h01;
            end
        end
    end
    // Outputs registered so they change just after the edge
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            valid_out <= 1'b0;
            lstart_out <= 1'b0;
            pix_out <= 8'h00;
            trig_out <= 1'b0;
            idx_out <= 8'h00;
        end else begin
            valid_out <= en_in && pos_q < LEN;
            lstart_out <= en_in && pos_q == 8'h00;
            pix_out <= (pos_q < LEN) ? {idx_q[6:0], 1'b0} : ~{idx_q[6:0], 1'b0};
            // Two cycles wide so the synchroniser cannot miss it
            trig_out <= en_in && pos_q < 8'h02;
            idx_out <= idx_q;
        end
    end
endmodule

/* tla_align_bench.sv */
// Purpose: Self-checking bench of the line alignment block
// Assumes: Sensor model streams 16-pixel lines every 20 clocks
// Notes:   Pixel values encode the line number to expose the delay
`timescale 1ns/1ps
`include "tla_defines.vh"
module tla_align_bench;
    reg        clk = 1'b0;
    reg        rst = 1'b1;
    reg [7:0]  addr = 8'h00;
    reg [31:0] wdata = 32'h0000_0000;
    reg        wr = 1'b0;
    reg        rd = 1'b0;
    reg        shaft = 1'b0;
    reg        ldir = 1'b0;
    reg        bwd = 1'b0;
    reg        en = 1'b0;
    reg        chk_on = 1'b0;
    reg [31:0] seed = 32'h0000_dbff;
    reg [31:0] d;
    wire [31:0] rdata;
    wire [7:0] pix;
    wire [7:0] idx;
    wire [7:0] r_o;
    wire [7:0] g_o;
    wire [7:0] b_o;
    wire       v_in, ls_in, trig, v_o, ls_o, dir_o, sw_o, paused;
    int        error_cnt = 0;
    int        checks = 0;
    int        cyc = 0;
    int        roff, boff, i, e;
    always #4 clk = ~clk;
    tla_sensor sens (.clk_in(clk), .rst_in(rst), .en_in(en), .valid_out(v_in),
        .lstart_out(ls_in), .pix_out(pix), .trig_out(trig), .idx_out(idx));
    tla_align #(.PIX_AW(4)) dut (.SYS_CLK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr),
        .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
        .PIX_VALID_IN(v_in), .LINE_START_IN(ls_in), .PIX_R_IN(pix), .PIX_G_IN(pix),
        .PIX_B_IN(pix), .TRIG_IN(trig), .SHAFT_DIR_IN(shaft), .LINE_DIR_IN(ldir),
        .BWD_PAUSE_IN(bwd), .PIX_VALID_OUT(v_o), .LINE_START_OUT(ls_o), .PIX_R_OUT(r_o),
        .PIX_G_OUT(g_o), .PIX_B_OUT(b_o), .MOTION_DIR_OUT(dir_o), .SW_LEVEL_OUT(sw_o),
        .PAUSED_OUT(paused));
    function automatic [31:0] lfsr(input [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Blend of line k back and k+1 back, as a delay in hundredths
    function automatic [31:0] px(input int n, input int dl);
        int k;
        int f;
        k = dl / 100;
        f = dl % 100;
        return ((2 * (n - k) * (100 - f) + 2 * (n - k - 1) * f) / 100) & 255;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic wrr(input [7:0] a, input [31:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdr(input [7:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic lines(input int n);
        repeat (n) @(posedge ls_o);
    endtask
    task automatic give_verdict;
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Hang guard well above the roughly 1100 clocks the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            give_verdict;
        end
    end
    always @(negedge clk) begin
        if (chk_on && v_o === 1'b1) begin
            chk(g_o, px(idx, 300));
            chk(r_o, px(idx, 300 + roff));
            chk(b_o, px(idx, 300 + boff));
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdr(`TLA_A_CTRL); chk(d, 32'h0000_0000);
        rdr(`TLA_A_MOVE); chk(d, 32'h0000_0064);
        rdr(`TLA_A_OFFSET); chk(d, 32'h0000_0000);
        rdr(`TLA_A_STATUS); chk(d, 32'h0000_0000);
        wrr(8'h24, 32'hFFFF_FFFF);
        rdr(8'h24); chk(d, 32'h0000_0000);
        rdr(`TLA_A_CTRL); chk(d, 32'h0000_0000);
        en <= 1'b1;
        // Every source with both settings, random pin and software levels
        for (i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            shaft <= seed[0];
            ldir <= seed[1];
            wrr(`TLA_A_CTRL, {26'h0, seed[2], 1'b0, i[1:0], i[2], 1'b1});
            repeat (30) @(posedge clk);
            e = (i[1:0] == 0) ? seed[0] : (i[1:0] == 1) ? seed[1] : (i[1:0] == 2) ? seed[2] : 0;
            #1 chk(dir_o, e ^ i[2]);
            chk(sw_o, seed[2]);
        end
        for (i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            roff = (i == 0) ? 300 : int'(seed[15:0] % 601) - 300;
            seed = lfsr(seed);
            boff = (i == 0) ? -300 : int'(seed[15:0] % 601) - 300;
            wrr(`TLA_A_CTRL, 32'h0000_0001);
            wrr(`TLA_A_OFFSET, {16'h0, roff[15:0]});
            wrr(`TLA_A_CTRL, 32'h0000_0011);
            wrr(`TLA_A_OFFSET, {16'h0, boff[15:0]});
            rdr(`TLA_A_OFFSET); chk(d, {16'h0, boff[15:0]});
            lines(2);
            chk_on = 1'b1;
            lines(3);
            chk_on = 1'b0;
            rdr(`TLA_A_RED); chk(d, {16'h0, roff[15:0]});
        end
        @(posedge clk);
        bwd <= 1'b1;
        @(posedge clk);
        #1 chk(paused, 1'b1);
        bwd <= 1'b0;
        rdr(`TLA_A_STATUS); chk(d & 32'h0000_0004, 32'h0000_0004);
        repeat (25) @(posedge clk);
        wrr(`TLA_A_CTRL, 32'h0000_0003);
        #1 chk(paused, 1'b0);
        lines(1);
        // Equal trigger and line periods give 100 times the line gap over the movement step
        wrr(`TLA_A_CTRL, 32'h0000_0008);
        lines(6);
        rdr(`TLA_A_TRIG); chk(d, 32'h0000_0014);
        rdr(`TLA_A_AUTO); chk(d, 32'h0000_00C8);
        rdr(`TLA_A_RED); chk(d, 32'h0000_00C8);
        rdr(`TLA_A_BLUE); chk(d, 32'h0000_FF38);
        wrr(`TLA_A_MOVE, 32'h0000_0190);
        wrr(`TLA_A_CTRL, 32'h0000_000A);
        lines(6);
        rdr(`TLA_A_RED); chk(d, 32'h0000_FFCE);
        rdr(`TLA_A_BLUE); chk(d, 32'h0000_0032);
        roff = -50;
        boff = 50;
        chk_on = 1'b1;
        lines(2);
        chk_on = 1'b0;
        wrr(`TLA_A_MOVE, 32'h0000_0032);
        lines(6);
        rdr(`TLA_A_AUTO); chk(d, 32'h0000_012C);
        give_verdict;
    end
endmodule
